//--- asbg_link_model.sv
// Far-end serial transceiver: drives the receive line and decodes the transmit line.
`timescale 1ns/1ns
module asbg_link_model #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clock,
  input wire logic tx_pin,
  input wire logic nine,
  output logic rx_pin
);
  logic [7:0] cap_d;
  logic cap_b9;
  int n_cap;

  // ==========================================================================
  // Line idles high; nothing captured yet.
  initial begin
    rx_pin = 1'b1;
    n_cap = 0;
  end

  // Decode at mid-bit; the count only moves at the middle of the stop bit.
  always @(negedge tx_pin) begin
    repeat (BIT_CYCLES / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clock);
      cap_d[i] = tx_pin;
    end
    repeat (BIT_CYCLES) @(posedge clock);
    cap_b9 = tx_pin;
    if (nine) repeat (BIT_CYCLES) @(posedge clock);
    n_cap++;
  end

  // Bit period kept exact so the receiver's mid-bit sampling is exercised.
  task automatic send_frame(input logic [7:0] d, input logic b9);
    logic [10:0] f;
    f = nine ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge clock);
      rx_pin <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge clock);
    end
  endtask
endmodule // asbg_link_model

//--- asbg_pkg.sv
// Shared constants, register map and types of the serial port with baud generator.
package asbg_pkg;

  // ==========================================================================
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_DATA = 5'h04;
  localparam logic [4:0] OFF_BAUD = 5'h08;
  localparam logic [4:0] OFF_TMR = 5'h0C;
  localparam logic [4:0] OFF_STAT = 5'h10;
  localparam logic [4:0] OFF_MASK = 5'h14;

  // ==========================================================================
  // Reset values and field positions.
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] TIMER_MAX = 8'hFF;
  localparam int FLAG_RX = 0;
  localparam int FLAG_TX = 1;
  localparam int TMR_RUN = 0;
  localparam int TMR_SEL_LSB = 1;

  // ==========================================================================
  // Baud timer input clock selection, prescaler terminal counts and the last data bit index.
  localparam logic [2:0] SEL_DIV4 = 3'h0;
  localparam logic [2:0] SEL_DIV12 = 3'h1;
  localparam logic [2:0] SEL_DIV48 = 3'h2;
  localparam logic [2:0] SEL_EXT_OSC = 3'h3;
  localparam logic [2:0] SEL_EXT_PIN = 3'h4;
  localparam logic [5:0] DIV4_LAST = 6'h03;
  localparam logic [5:0] DIV12_LAST = 6'h0B;
  localparam logic [5:0] DIV48_LAST = 6'h2F;
  localparam logic [2:0] OSC_DIV_LAST = 3'h7;
  localparam logic [2:0] DATA_BIT_LAST = 3'h7;

  // ==========================================================================
  // Types.
  typedef struct packed {
    logic frame_format_select;
    logic unused_one;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } asbg_ctrl_t;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic run;
  } asbg_tmr_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_DATA = 3'b010,
    S_NINTH = 3'b011,
    S_STOP = 3'b100
  } asbg_state_t;

endpackage

//--- asbg_uart.sv
// Serial port with 8-bit and 9-bit frames, buffered receive and baud timer.
`timescale 1ns/1ns

module asbg_uart (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic ext_osc_pin,
  input wire logic timer_ext_input,
  output logic irq
);

  // Next auto-reload count of an 8-bit timer on one input tick.
  function automatic logic [7:0] asbg_step(input logic [7:0] cnt, input logic [7:0] rld);
    asbg_step = (cnt == asbg_pkg::TIMER_MAX) ? rld : cnt + 8'h01;
  endfunction

  // ==========================================================================
  // Pin synchronisers.
  logic [2:0] rx_sync, osc_sync, ext_sync;
  logic rxd, rx_fall, osc_rise, ext_rise;

  // Bit 0 feeds only bit 1; edges are taken between bits 1 and 2.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_sync <= 3'h7;
      osc_sync <= 3'h0;
      ext_sync <= 3'h0;
    end else if (clk_en) begin
      rx_sync <= {rx_sync[1:0], rx_pin};
      osc_sync <= {osc_sync[1:0], ext_osc_pin};
      ext_sync <= {ext_sync[1:0], timer_ext_input};
    end
  end

  assign rxd = rx_sync[1];
  assign rx_fall = rx_sync[2] & ~rx_sync[1];
  assign osc_rise = osc_sync[1] & ~osc_sync[2];
  assign ext_rise = ext_sync[1] & ~ext_sync[2];

  // ==========================================================================
  // Register state and bus strobes.
  asbg_pkg::asbg_ctrl_t ctrl, next_ctrl;
  asbg_pkg::asbg_tmr_t tmr, next_tmr;
  logic [7:0] reload, next_reload, rx_buf, next_rx_buf, tx_hold, next_tx_hold;
  logic [1:0] mask, next_mask;
  logic tx_pend, next_tx_pend;
  logic next_waitrequest, next_irq;
  logic [31:0] next_readdata;
  logic acc_wr, wr_ctrl, wr_data, wr_baud, wr_tmr, wr_stat, wr_mask;
  logic set_tx, set_rx, take_tx, load_rx;
  logic [7:0] rx_data_in;
  logic rx_bit9_in;

  // A write lands only at the edge where the master sees waitrequest low.
  assign acc_wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign wr_ctrl = acc_wr && avs_address == asbg_pkg::OFF_CTRL;
  assign wr_data = acc_wr && avs_address == asbg_pkg::OFF_DATA;
  assign wr_baud = acc_wr && avs_address == asbg_pkg::OFF_BAUD;
  assign wr_tmr = acc_wr && avs_address == asbg_pkg::OFF_TMR;
  assign wr_stat = acc_wr && avs_address == asbg_pkg::OFF_STAT;
  assign wr_mask = acc_wr && avs_address == asbg_pkg::OFF_MASK;

  // ==========================================================================
  // Baud timer prescaler and the two auto-reload timers.
  logic [5:0] pre, next_pre;
  logic [2:0] osc_cnt, next_osc_cnt;
  logic [7:0] tx_tmr, next_tx_tmr, rx_tmr, next_rx_tmr;
  logic tx_half, next_tx_half, rx_half, next_rx_half;
  logic tick, tx_ovf, rx_ovf, tx_tick, rx_tick, start_force;
  logic [5:0] pre_last;
  asbg_pkg::asbg_state_t tx_st, next_tx_st, rx_st, next_rx_st;

  // The prescaler runs freely so that the chosen source phase is not reset on start.
  always_comb begin
    next_pre = pre;
    next_osc_cnt = osc_cnt;
    tick = 1'b0;
    unique case (tmr.clk_sel)
      asbg_pkg::SEL_DIV12: pre_last = asbg_pkg::DIV12_LAST;
      asbg_pkg::SEL_DIV48: pre_last = asbg_pkg::DIV48_LAST;
      default: pre_last = asbg_pkg::DIV4_LAST;
    endcase
    if (tmr.clk_sel == asbg_pkg::SEL_EXT_OSC) begin
      if (osc_rise) begin
        tick = osc_cnt == asbg_pkg::OSC_DIV_LAST;
        next_osc_cnt = osc_cnt + 3'h1;
      end
    end else if (tmr.clk_sel == asbg_pkg::SEL_EXT_PIN) begin
      tick = ext_rise;
    end else begin
      tick = pre >= pre_last;
      next_pre = tick ? 6'h00 : pre + 6'h01;
    end
    tick = tick & tmr.run;
    start_force = rx_st == asbg_pkg::S_IDLE && ctrl.rx_enable && rx_fall;
    tx_ovf = tick && tx_tmr == asbg_pkg::TIMER_MAX;
    rx_ovf = tick && rx_tmr == asbg_pkg::TIMER_MAX && !start_force;
    next_tx_tmr = tick ? asbg_step(tx_tmr, reload) : tx_tmr;
    next_tx_half = tx_half ^ tx_ovf;
    tx_tick = tx_ovf & tx_half;
    if (start_force) begin
      next_rx_tmr = reload;
      next_rx_half = 1'b0;
    end else begin
      next_rx_tmr = tick ? asbg_step(rx_tmr, reload) : rx_tmr;
      next_rx_half = rx_half ^ rx_ovf;
    end
    // First overflow after the start edge is half a bit in: mid-bit sampling.
    rx_tick = rx_ovf & ~rx_half;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pre <= 6'h00;
      osc_cnt <= 3'h0;
      tx_tmr <= asbg_pkg::BYTE_ZERO;
      rx_tmr <= asbg_pkg::BYTE_ZERO;
      tx_half <= 1'b0;
      rx_half <= 1'b0;
    end else if (clk_en) begin
      pre <= next_pre;
      osc_cnt <= next_osc_cnt;
      tx_tmr <= next_tx_tmr;
      rx_tmr <= next_rx_tmr;
      tx_half <= next_tx_half;
      rx_half <= next_rx_half;
    end
  end

  // ==========================================================================
  // Transmitter.
  logic [7:0] tx_shift, next_tx_shift;
  logic [2:0] tx_cnt, next_tx_cnt;
  logic next_tx_pin;

  // The shifter is apart from the holding register, so a new write never garbles a frame.
  always_comb begin
    next_tx_st = tx_st;
    next_tx_shift = tx_shift;
    next_tx_cnt = tx_cnt;
    next_tx_pin = tx_pin;
    set_tx = 1'b0;
    take_tx = 1'b0;
    if (tx_tick) begin
      unique case (tx_st)
        asbg_pkg::S_IDLE: begin
          if (tx_pend) begin
            take_tx = 1'b1;
            next_tx_shift = tx_hold;
            next_tx_pin = 1'b0;
            next_tx_st = asbg_pkg::S_START;
          end
        end
        asbg_pkg::S_START: begin
          next_tx_pin = tx_shift[0];
          next_tx_cnt = 3'h0;
          next_tx_st = asbg_pkg::S_DATA;
        end
        asbg_pkg::S_DATA: begin
          if (tx_cnt == asbg_pkg::DATA_BIT_LAST) begin
            if (ctrl.frame_format_select) begin
              next_tx_pin = ctrl.tx_ninth_bit;
              next_tx_st = asbg_pkg::S_NINTH;
            end else begin
              next_tx_pin = 1'b1;
              set_tx = 1'b1;
              next_tx_st = asbg_pkg::S_STOP;
            end
          end else begin
            next_tx_shift = {1'b0, tx_shift[7:1]};
            next_tx_pin = tx_shift[1];
            next_tx_cnt = tx_cnt + 3'h1;
          end
        end
        asbg_pkg::S_NINTH: begin
          next_tx_pin = 1'b1;
          set_tx = 1'b1;
          next_tx_st = asbg_pkg::S_STOP;
        end
        default: next_tx_st = asbg_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_st <= asbg_pkg::S_IDLE;
      tx_shift <= asbg_pkg::BYTE_ZERO;
      tx_cnt <= 3'h0;
      tx_pin <= 1'b1;
    end else if (clk_en) begin
      tx_st <= next_tx_st;
      tx_shift <= next_tx_shift;
      tx_cnt <= next_tx_cnt;
      tx_pin <= next_tx_pin;
    end
  end

  // ==========================================================================
  // Receiver.
  logic [7:0] rx_shift, next_rx_shift;
  logic [2:0] rx_cnt, next_rx_cnt;
  logic rx_bit9, next_rx_bit9;

  // Disabling reception drops a frame in progress; the buffer keeps the last byte.
  always_comb begin
    next_rx_st = rx_st;
    next_rx_shift = rx_shift;
    next_rx_cnt = rx_cnt;
    next_rx_bit9 = rx_bit9;
    load_rx = 1'b0;
    rx_data_in = rx_shift;
    rx_bit9_in = ctrl.frame_format_select ? rx_bit9 : rxd;
    if (!ctrl.rx_enable) begin
      next_rx_st = asbg_pkg::S_IDLE;
    end else if (start_force) begin
      next_rx_st = asbg_pkg::S_START;
    end else if (rx_tick) begin
      unique case (rx_st)
        asbg_pkg::S_IDLE: next_rx_st = asbg_pkg::S_IDLE;
        asbg_pkg::S_START: begin
          next_rx_cnt = 3'h0;
          next_rx_st = rxd ? asbg_pkg::S_IDLE : asbg_pkg::S_DATA;
        end
        asbg_pkg::S_DATA: begin
          next_rx_shift = {rxd, rx_shift[7:1]};
          next_rx_cnt = rx_cnt + 3'h1;
          if (rx_cnt == asbg_pkg::DATA_BIT_LAST) begin
            next_rx_st = ctrl.frame_format_select ? asbg_pkg::S_NINTH : asbg_pkg::S_STOP;
          end
        end
        asbg_pkg::S_NINTH: begin
          next_rx_bit9 = rxd;
          next_rx_st = asbg_pkg::S_STOP;
        end
        default: begin
          // A full receive flag drops the new byte so the buffered one survives overrun.
          load_rx = !ctrl.rx_done_flag && (!ctrl.multiproc_enable || rx_bit9_in);
          next_rx_st = asbg_pkg::S_IDLE;
        end
      endcase
    end
  end
  assign set_rx = load_rx;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_st <= asbg_pkg::S_IDLE;
      rx_shift <= asbg_pkg::BYTE_ZERO;
      rx_cnt <= 3'h0;
      rx_bit9 <= 1'b0;
    end else if (clk_en) begin
      rx_st <= next_rx_st;
      rx_shift <= next_rx_shift;
      rx_cnt <= next_rx_cnt;
      rx_bit9 <= next_rx_bit9;
    end
  end

  // ==========================================================================
  // Registers, interrupt and Avalon-MM answer.
  logic [1:0] flags, next_flags;

  // Hardware sets win over a same-cycle write-one clear.
  always_comb begin
    next_ctrl = ctrl;
    next_tmr = tmr;
    next_reload = wr_baud ? avs_writedata[7:0] : reload;
    next_mask = wr_mask ? avs_writedata[1:0] : mask;
    next_tx_hold = wr_data ? avs_writedata[7:0] : tx_hold;
    next_tx_pend = wr_data | (tx_pend & ~take_tx);
    next_rx_buf = load_rx ? rx_data_in : rx_buf;
    if (wr_ctrl) begin
      next_ctrl.frame_format_select = avs_writedata[7];
      next_ctrl.multiproc_enable = avs_writedata[5];
      next_ctrl.rx_enable = avs_writedata[4];
      next_ctrl.tx_ninth_bit = avs_writedata[3];
    end
    if (load_rx) begin
      next_ctrl.rx_ninth_bit = rx_bit9_in;
    end
    if (wr_tmr) begin
      next_tmr = avs_writedata[3:0];
    end
    flags = {ctrl.tx_done_flag, ctrl.rx_done_flag};
    // Only software clears a flag, never the act of answering the interrupt.
    next_flags = flags & ~({2{wr_stat}} & avs_writedata[1:0]);
    next_flags = next_flags | {set_tx, set_rx};
    next_ctrl.tx_done_flag = next_flags[asbg_pkg::FLAG_TX];
    next_ctrl.rx_done_flag = next_flags[asbg_pkg::FLAG_RX];
    next_irq = |(next_flags & next_mask);
    next_waitrequest = !((avs_read | avs_write) && avs_waitrequest);
    next_readdata = 32'h0000_0000;
    if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        asbg_pkg::OFF_CTRL: next_readdata[7:0] = ctrl;
        asbg_pkg::OFF_DATA: next_readdata[7:0] = rx_buf;
        asbg_pkg::OFF_BAUD: next_readdata[7:0] = reload;
        asbg_pkg::OFF_TMR: next_readdata[15:0] = {tx_tmr, 4'h0, tmr};
        asbg_pkg::OFF_STAT: next_readdata[1:0] = flags;
        asbg_pkg::OFF_MASK: next_readdata[1:0] = mask;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl <= asbg_pkg::CTRL_RESET;
      tmr <= 4'h0;
      reload <= asbg_pkg::BYTE_ZERO;
      mask <= 2'h0;
      tx_hold <= asbg_pkg::BYTE_ZERO;
      tx_pend <= 1'b0;
      rx_buf <= asbg_pkg::BYTE_ZERO;
      irq <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      ctrl <= next_ctrl;
      tmr <= next_tmr;
      reload <= next_reload;
      mask <= next_mask;
      tx_hold <= next_tx_hold;
      tx_pend <= next_tx_pend;
      rx_buf <= next_rx_buf;
      irq <= next_irq;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

endmodule // asbg_uart

//--- asbg_uart_asserts.sv
// Checker of bus, serial line and interrupt timing of the serial port.
`timescale 1ns/1ns
module asbg_uart_asserts (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic tx_pin,
  input wire logic irq
);
  logic [1:0] mask;
  logic [1:0] next_mask;
  logic sent;
  logic next_sent;

  // ==========================================================================
  // Shadow of the mask and of whether any byte was ever handed to transmit.
  always_comb begin
    next_mask = mask;
    next_sent = sent;
    if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
      if (avs_address == asbg_pkg::OFF_MASK) next_mask = avs_writedata[1:0];
      if (avs_address == asbg_pkg::OFF_DATA) next_sent = 1'b1;
    end
  end

  // Both shadows clear in reset, as the design's own registers do.
  always_ff @(posedge clock) begin
    mask <= rst_b ? next_mask : 2'h0;
    sent <= rst_b ? next_sent : 1'b0;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Bus handshake: one wait state, low for one cycle, silent when idle.
  chk_wait_answer:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop after a request");
  chk_wait_single:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_wait_idle:
    assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");
  chk_ctrl_read:
    assert property (avs_read && !avs_waitrequest && avs_address == asbg_pkg::OFF_CTRL
      |-> avs_readdata[6] && avs_readdata[31:8] == 24'h000000)
    else $error("control read has a wrong fixed bit");
  // Serial line: no bit shorter than two overflows of the fastest timer clock.
  chk_tx_spacing:
    assert property ($changed(tx_pin) |=> $stable(tx_pin) [*3])
    else $error("transmit line changed too soon");
  chk_tx_quiet:
    assert property (!sent |-> tx_pin)
    else $error("transmit line left idle with no byte written");
  // Interrupt: sticky flags, only a bus write can lower it, mask gates it.
  chk_irq_sticky:
    assert property (irq && !avs_write && !$past(avs_write) |=> irq)
    else $error("interrupt dropped without a software write");
  chk_mask_off:
    assert property (mask == 2'h0 && $past(mask) == 2'h0 |-> !irq)
    else $error("interrupt high while fully masked");
  chk_irq_cause:
    assert property ($rose(irq) |-> mask != 2'h0)
    else $error("interrupt rose with mask clear");
  cov_tx_frame: cover property ($fell(tx_pin));
  cov_irq: cover property ($rose(irq));
  cov_read: cover property (avs_read && !avs_waitrequest);
endmodule // asbg_uart_asserts

//--- async_serial_port_baud_gen_test.sv
// Self-checking bench of the serial port: bus, frames both ways, flags, interrupt.
`timescale 1ns/1ns
module async_serial_port_baud_gen_test;
  logic clock;
  logic rst_b;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_pin;
  logic tx_pin;
  logic irq;
  logic nine;
  logic b9;
  logic tpin;
  logic opin;
  logic [31:0] q;
  logic [7:0] d;
  logic [7:0] cfg;
  logic [7:0] last;
  int n0;
  int n_errors;
  int n_checks;
  integer seed;

  // ==========================================================================
  // Design, far end and clock.
  asbg_uart u_dut (.clock(clock), .rst_b(rst_b), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .ext_osc_pin(opin), .timer_ext_input(tpin), .irq(irq));
  asbg_link_model #(.BIT_CYCLES(16)) u_link (.clock(clock), .tx_pin(tx_pin), .nine(nine),
    .rx_pin(rx_pin));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Compare and count; an unknown never matches.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One bus access held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, wd};
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      finish_test();
    end
  endtask

  task automatic rdc(input string n, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    check(n, q, e);
  endtask

  // Bounded waits; running out ends the run as a failure.
  task automatic wait_irq();
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clock);
    check("irq raised", {31'h0, irq}, 32'h1);
    if (irq !== 1'b1) finish_test();
  endtask

  task automatic wait_cap();
    for (int i = 0; i < 4000 && u_link.n_cap == n0; i++) @(posedge clock);
    if (u_link.n_cap == n0) begin
      n_errors++;
      finish_test();
    end
  endtask

  // Expected control readback and expected last bit of a frame.
  function automatic logic [31:0] ctrl_exp(input logic [7:0] c, input logic [1:0] fl);
    return {24'h000000, c[7], 1'b1, c[5:3], 1'b1, fl};
  endfunction
  function automatic logic last_bit(input logic n9, input logic tb8);
    return n9 ? tb8 : 1'b1;
  endfunction

  // Main sequence: reset values, transmit in both formats, receive with drops.
  initial begin
    seed = 32'hCC890C74;
    rst_b = 1'b0;
    {avs_read, avs_write, nine, tpin, opin} = 5'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    last = 8'h00;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    rdc("ctrl reset", asbg_pkg::OFF_CTRL, {24'h000000, asbg_pkg::CTRL_RESET});
    rdc("data reset", asbg_pkg::OFF_DATA, 32'h00000000);
    rdc("unmapped", 5'h18, 32'h00000000);
    bus(1'b1, asbg_pkg::OFF_BAUD, 8'hFE);
    bus(1'b1, asbg_pkg::OFF_TMR, 8'h01);
    bus(1'b1, asbg_pkg::OFF_MASK, 8'h03);
    for (int m = 0; m < 4; m++) begin
      nine = m > 1;
      cfg = m > 1 ? (m == 3 ? 8'h98 : 8'h90) : 8'h10;
      bus(1'b1, asbg_pkg::OFF_CTRL, cfg);
      d = (m == 0) ? 8'hFF : 8'($random(seed));
      n0 = u_link.n_cap;
      bus(1'b1, asbg_pkg::OFF_DATA, d);
      wait_irq();
      check("done before stop end", u_link.n_cap, n0);
      rdc("rx kept on tx", asbg_pkg::OFF_DATA, {24'h000000, last});
      wait_cap();
      check("tx data", {24'h000000, u_link.cap_d}, {24'h000000, d});
      check("tx last", {31'h0, u_link.cap_b9}, {31'h0, last_bit(nine, cfg[3])});
      rdc("tx done", asbg_pkg::OFF_STAT, 32'h00000002);
      bus(1'b1, asbg_pkg::OFF_STAT, 8'h02);
    end
    for (int m = 0; m < 4; m++) begin
      nine = m > 1;
      cfg = m > 1 ? 8'hB0 : 8'h10;
      bus(1'b1, asbg_pkg::OFF_CTRL, cfg);
      d = 8'($random(seed));
      b9 = m != 2;
      u_link.send_frame(d, b9);
      if (b9) last = d;
      if (m == 0) u_link.send_frame(~d, 1'b1);
      rdc("rx flag", asbg_pkg::OFF_STAT, {31'h0, b9});
      rdc("rx data", asbg_pkg::OFF_DATA, {24'h000000, last});
      rdc("ctrl rx", asbg_pkg::OFF_CTRL, ctrl_exp(cfg, {1'b0, b9}));
      check("irq level", {31'h0, irq}, {31'h0, b9});
      if (m == 1) bus(1'b1, asbg_pkg::OFF_MASK, 8'h00);
      if (m == 1) rdc("masked", asbg_pkg::OFF_STAT, 32'h00000001);
      if (m == 1) check("irq masked", {31'h0, irq}, 32'h0);
      bus(1'b1, asbg_pkg::OFF_MASK, 8'h03);
      bus(1'b1, asbg_pkg::OFF_STAT, 8'h01);
    end
    // External sources: a zero reload lets the count simply wrap, so the step is exact.
    bus(1'b1, asbg_pkg::OFF_BAUD, 8'h00);
    bus(1'b1, asbg_pkg::OFF_TMR, 8'h09);
    bus(1'b0, asbg_pkg::OFF_TMR, 8'h00);
    d = q[15:8];
    for (int k = 0; k < 3; k++) begin
      tpin <= 1'b1;
      repeat (4) @(posedge clock);
      tpin <= 1'b0;
      repeat (4) @(posedge clock);
    end
    rdc("ext pin count", asbg_pkg::OFF_TMR, {16'h0000, 8'(d + 8'h03), 8'h09});
    bus(1'b1, asbg_pkg::OFF_TMR, 8'h07);
    bus(1'b0, asbg_pkg::OFF_TMR, 8'h00);
    d = q[15:8];
    for (int k = 0; k < 16; k++) begin
      opin <= 1'b1;
      repeat (4) @(posedge clock);
      opin <= 1'b0;
      repeat (4) @(posedge clock);
    end
    rdc("osc count", asbg_pkg::OFF_TMR, {16'h0000, 8'(d + 8'h02), 8'h07});
    finish_test();
  end
endmodule // async_serial_port_baud_gen_test

bind asbg_uart asbg_uart_asserts u_chk (.clock(clock), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_pin(tx_pin), .irq(irq));
